/* File: src/flash_id_otp_pkg.sv */
/*
  Constants and types for the identification, four-line mode and
  one-time-programmable command slice of a serial flash.
  Assumes a single system clock that samples the serial pins.
*/
package flash_id_otp_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_ID_DUAL = 8'h92;
  localparam logic [7:0] OP_ID_QUAD = 8'h94;
  localparam logic [7:0] OP_ID_STD = 8'h9f;
  localparam logic [7:0] OP_QMODE_ON = 8'h38;
  localparam logic [7:0] OP_QMODE_OFF = 8'hff;
  localparam logic [7:0] OP_OTP_ENTER = 8'hb1;
  localparam logic [7:0] OP_OTP_EXIT = 8'hc1;
  localparam logic [7:0] OP_SEC_READ = 8'h2b;
  localparam logic [7:0] OP_SEC_WRITE = 8'h2f;

  // ==========================================================
  // field layout and timing counts
  localparam logic [5:0] OPCODE_BITS = 6'd8;
  localparam logic [5:0] ADDR_MODE_BITS = 6'd32;
  localparam logic [5:0] DATA_BITS = 6'd8;
  localparam int ADDR_LSB_POS = 8;
  localparam logic [3:0] DUAL_GAP_CLKS = 4'd0;
  localparam logic [3:0] QUAD_GAP_CLKS = 4'd4;
  localparam int SEC_FACTORY_BIT = 0;
  localparam int SEC_CUSTOMER_BIT = 1;
  localparam logic [5:0] SEC_RESERVED_VAL = 6'h00;
  localparam logic [23:0] SN_FIRST = 24'h000000;
  localparam logic [23:0] SN_LAST = 24'h00000f;
  localparam logic [23:0] OTP_LAST = 24'h0001ff;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    st_idle, st_opcode, st_addr, st_gap, st_out,
    st_wdata, st_wdone, st_exec, st_ffseq, st_ignore
  } state_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } pins_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } drive_t;

endpackage : flash_id_otp_pkg

/* File: src/flash_id_otp.sv */
/*
  Command slice of a serial flash: ID reads, four-line mode entry
  and exit, OTP mode and the security byte.
  Assumes the serial pins are asynchronous to clk and much slower;
  the array engines and the non-volatile store sit outside.
*/
`timescale 1ns/1ps
module flash_id_otp #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h15, // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h28, // arbitrary value
  parameter logic [7:0] CAPACITY = 8'h16 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial pins, outside the clock domain
  input wire flash_id_otp_pkg::pins_t pin_in,
  output flash_id_otp_pkg::drive_t pin_drive,
  // stored and configuration state from neighbouring logic
  input wire logic quad_enable_bit,
  input wire logic factory_lock_in,
  input wire logic customer_lock_in,
  input wire logic [23:0] access_addr,
  // mode and permission state
  output logic four_line_command_mode,
  output logic otp_mode,
  output logic customer_lock_flag,
  output logic array_write_block,
  output logic status_write_block,
  output logic otp_program_allowed,
  output logic serial_number_hit,
  output logic otp_addr_valid
);

  // ==========================================================
  // pin synchronisers and edge detection
  flash_id_otp_pkg::pins_t pin_m_q;
  flash_id_otp_pkg::pins_t pin_s_q;
  logic sclk_d_q;
  logic cs_d_q;

  // two flops before anything looks at the pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_m_q <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
      pin_s_q <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
      sclk_d_q <= 1'b0;
      cs_d_q <= 1'b1;
    end else begin
      pin_m_q <= pin_in;
      pin_s_q <= pin_m_q;
      sclk_d_q <= pin_s_q.sclk;
      cs_d_q <= pin_s_q.cs_n;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  assign sclk_rise = pin_s_q.sclk & ~sclk_d_q & ~pin_s_q.cs_n;
  assign sclk_fall = ~pin_s_q.sclk & sclk_d_q & ~pin_s_q.cs_n;
  assign cs_rise = pin_s_q.cs_n & ~cs_d_q;

  // ==========================================================
  // command state
  flash_id_otp_pkg::state_t state_q;
  logic [7:0] cmd_q;
  logic [31:0] shift_q;
  logic [5:0] cnt_q;
  logic [2:0] in_lanes_q;
  logic [2:0] out_lanes_q;
  logic [3:0] gap_q;
  logic order_q;
  logic [7:0] wdata_q;
  logic quad_q;
  logic otp_q;
  logic factory_q;
  logic customer_q;
  logic loaded_q;

  // input lanes: opcode width follows the mode
  logic [2:0] lanes_in;
  logic [31:0] shift_d;
  logic [5:0] cnt_d;

  always_comb begin
    if (state_q == flash_id_otp_pkg::st_opcode) begin
      lanes_in = quad_q ? 3'd4 : 3'd1;
    end else begin
      lanes_in = in_lanes_q;
    end
    unique case (lanes_in)
      3'd2: shift_d = {shift_q[29:0], pin_s_q.io[1:0]};
      3'd4: shift_d = {shift_q[27:0], pin_s_q.io};
      default: shift_d = {shift_q[30:0], pin_s_q.io[0]};
    endcase
    cnt_d = cnt_q + {3'd0, lanes_in};
  end

  // the byte just completed by this edge
  logic [7:0] byte_in;
  assign byte_in = shift_d[7:0];

  // sequencer: select moves idle to opcode; bits shift and decode only on synchronised sclk rising edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= flash_id_otp_pkg::st_idle;
      cmd_q <= 8'h00;
      shift_q <= 32'h0000_0000;
      cnt_q <= 6'd0;
      in_lanes_q <= 3'd1;
      out_lanes_q <= 3'd1;
      gap_q <= 4'd0;
      order_q <= 1'b0;
      wdata_q <= 8'h00;
    end else if (pin_s_q.cs_n) begin
      state_q <= flash_id_otp_pkg::st_idle;
      cnt_q <= 6'd0;
    end else if (state_q == flash_id_otp_pkg::st_idle) begin
      state_q <= flash_id_otp_pkg::st_opcode;
      cnt_q <= 6'd0;
    end else if (sclk_rise) begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      unique case (state_q)
        flash_id_otp_pkg::st_opcode: begin
          if (cnt_d == flash_id_otp_pkg::OPCODE_BITS) begin
            cmd_q <= byte_in;
            cnt_q <= 6'd0;
            order_q <= 1'b0;
            out_lanes_q <= quad_q ? 3'd4 : 3'd1;
            in_lanes_q <= quad_q ? 3'd4 : 3'd1;
            unique case (byte_in)
              flash_id_otp_pkg::OP_ID_STD,
              flash_id_otp_pkg::OP_SEC_READ:
                state_q <= flash_id_otp_pkg::st_out;
              flash_id_otp_pkg::OP_ID_DUAL: begin
                // dual form exists only in serial mode
                state_q <= quad_q ? flash_id_otp_pkg::st_ignore
                                  : flash_id_otp_pkg::st_addr;
                in_lanes_q <= 3'd2;
                out_lanes_q <= 3'd2;
                gap_q <= flash_id_otp_pkg::DUAL_GAP_CLKS;
              end
              flash_id_otp_pkg::OP_ID_QUAD: begin
                state_q <= flash_id_otp_pkg::st_addr;
                in_lanes_q <= 3'd4;
                out_lanes_q <= 3'd4;
                gap_q <= flash_id_otp_pkg::QUAD_GAP_CLKS;
              end
              flash_id_otp_pkg::OP_QMODE_ON: begin
                // only from serial mode, only with quad enable
                if (!quad_q && quad_enable_bit) begin
                  state_q <= flash_id_otp_pkg::st_exec;
                end else begin
                  state_q <= flash_id_otp_pkg::st_ignore;
                end
              end
              flash_id_otp_pkg::OP_QMODE_OFF: begin
                state_q <= quad_q ? flash_id_otp_pkg::st_ffseq
                                  : flash_id_otp_pkg::st_ignore;
              end
              flash_id_otp_pkg::OP_OTP_ENTER,
              flash_id_otp_pkg::OP_OTP_EXIT:
                state_q <= flash_id_otp_pkg::st_exec;
              flash_id_otp_pkg::OP_SEC_WRITE:
                state_q <= flash_id_otp_pkg::st_wdata;
              default: state_q <= flash_id_otp_pkg::st_ignore;
            endcase
          end
        end
        flash_id_otp_pkg::st_addr: begin
          // 24 address bits then 8 mode bits
          if (cnt_d == flash_id_otp_pkg::ADDR_MODE_BITS) begin
            order_q <= shift_d[flash_id_otp_pkg::ADDR_LSB_POS];
            if (gap_q == 4'd0) begin
              state_q <= flash_id_otp_pkg::st_out;
            end else begin
              state_q <= flash_id_otp_pkg::st_gap;
            end
          end
        end
        flash_id_otp_pkg::st_gap: begin
          gap_q <= gap_q - 4'd1;
          if (gap_q == 4'd1) begin
            state_q <= flash_id_otp_pkg::st_out;
          end
        end
        flash_id_otp_pkg::st_wdata: begin
          if (cnt_d == flash_id_otp_pkg::DATA_BITS) begin
            wdata_q <= byte_in;
            state_q <= flash_id_otp_pkg::st_wdone;
          end
        end
        // any clock past the last bit spoils the command
        flash_id_otp_pkg::st_wdone,
        flash_id_otp_pkg::st_exec:
          state_q <= flash_id_otp_pkg::st_ignore;
        flash_id_otp_pkg::st_ffseq: begin
          // further bytes must stay all ones
          if (pin_s_q.io != 4'hf) begin
            state_q <= flash_id_otp_pkg::st_ignore;
          end
        end
        flash_id_otp_pkg::st_out,
        flash_id_otp_pkg::st_ignore,
        flash_id_otp_pkg::st_idle: state_q <= state_q;
      endcase
    end
  end

  // ==========================================================
  // output shifter: loads a byte, then shifts on falling edges
  logic [7:0] out_sr_q;
  logic [3:0] out_left_q;
  logic [1:0] idx_q;
  logic [7:0] sec_byte;
  logic [7:0] next_byte;
  logic [1:0] idx_next;

  assign sec_byte = {flash_id_otp_pkg::SEC_RESERVED_VAL,
                     customer_q, factory_q};

  // byte choice per command and position in the stream
  always_comb begin
    next_byte = sec_byte;
    idx_next = idx_q;
    if (cmd_q == flash_id_otp_pkg::OP_ID_STD) begin
      unique case (idx_q)
        2'd1: next_byte = MEM_TYPE;
        2'd2: next_byte = CAPACITY;
        default: next_byte = MAKER_ID;
      endcase
      idx_next = (idx_q == 2'd2) ? 2'd0 : idx_q + 2'd1;
    end else if (cmd_q != flash_id_otp_pkg::OP_SEC_READ) begin
      // maker first unless the address ended in one
      next_byte = (idx_q[0] ^ order_q) ? DEVICE_ID
                                       : MAKER_ID;
      idx_next = {1'b0, ~idx_q[0]};
    end
  end

  // bits presented for the current lane width
  function automatic flash_id_otp_pkg::drive_t present(
      input logic [7:0] sr, input logic [2:0] lanes);
    flash_id_otp_pkg::drive_t d;
    d = '{out: 4'h0, oe: 4'h0};
    unique case (lanes)
      3'd2: d = '{out: {2'b00, sr[7:6]}, oe: 4'h3};
      3'd4: d = '{out: sr[7:4], oe: 4'hf};
      default: d = '{out: {2'b00, sr[7], 1'b0}, oe: 4'h2};
    endcase
    return d;
  endfunction : present

  // shift data out msb first; lines float outside data phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_sr_q <= 8'h00;
      out_left_q <= 4'd0;
      idx_q <= 2'd0;
      pin_drive <= '{out: 4'h0, oe: 4'h0};
    end else if (state_q != flash_id_otp_pkg::st_out ||
                 pin_s_q.cs_n) begin
      out_left_q <= 4'd0;
      idx_q <= 2'd0;
      pin_drive <= '{out: 4'h0, oe: 4'h0};
    end else if (sclk_fall) begin
      if (out_left_q == 4'd0) begin
        pin_drive <= present(next_byte, out_lanes_q);
        out_sr_q <= next_byte << out_lanes_q;
        out_left_q <= 4'd8 - {1'b0, out_lanes_q};
        idx_q <= idx_next;
      end else begin
        pin_drive <= present(out_sr_q, out_lanes_q);
        out_sr_q <= out_sr_q << out_lanes_q;
        out_left_q <= out_left_q - {1'b0, out_lanes_q};
      end
    end
  end

  // ==========================================================
  // mode and lock state, acted on at chip select rise
  // write latch, suspend and wrap live elsewhere and are never
  // touched here, so mode changes keep them as they were
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quad_q <= 1'b0;
      otp_q <= 1'b0;
    end else if (cs_rise) begin
      if (state_q == flash_id_otp_pkg::st_exec) begin
        unique case (cmd_q)
          flash_id_otp_pkg::OP_QMODE_ON: quad_q <= 1'b1;
          flash_id_otp_pkg::OP_OTP_ENTER: otp_q <= 1'b1;
          flash_id_otp_pkg::OP_OTP_EXIT: otp_q <= 1'b0;
          default: otp_q <= otp_q;
        endcase
      end else if (state_q == flash_id_otp_pkg::st_ffseq) begin
        quad_q <= 1'b0;
      end
    end
  end

  // stored lock bits load once after reset release; the customer
  // bit can only go from 0 to 1, so a lock is permanent
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded_q <= 1'b0;
      factory_q <= 1'b0;
      customer_q <= 1'b0;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      factory_q <= factory_lock_in;
      customer_q <= customer_lock_in;
    end else if (cs_rise &&
                 state_q == flash_id_otp_pkg::st_wdone &&
                 !otp_q) begin
      customer_q <= customer_q |
                    wdata_q[flash_id_otp_pkg::SEC_CUSTOMER_BIT];
    end
  end

  // ==========================================================
  // permission and address outputs, all registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      array_write_block <= 1'b0;
      status_write_block <= 1'b0;
      otp_program_allowed <= 1'b0;
      serial_number_hit <= 1'b0;
      otp_addr_valid <= 1'b0;
    end else begin
      array_write_block <= otp_q;
      status_write_block <= otp_q;
      otp_program_allowed <= otp_q & ~factory_q & ~customer_q;
      serial_number_hit <= otp_q &&
        access_addr >= flash_id_otp_pkg::SN_FIRST &&
        access_addr <= flash_id_otp_pkg::SN_LAST;
      otp_addr_valid <= otp_q &&
        access_addr <= flash_id_otp_pkg::OTP_LAST;
    end
  end

  // copies of internal state on dedicated output flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      four_line_command_mode <= 1'b0;
      otp_mode <= 1'b0;
      customer_lock_flag <= 1'b0;
    end else begin
      four_line_command_mode <= quad_q;
      otp_mode <= otp_q;
      customer_lock_flag <= customer_q;
    end
  end

endmodule : flash_id_otp

/* File: sim/flash_id_otp_properties.sv */
/*
  Checker for the ID, four-line mode and OTP command slice.
  Assumes it is bound to flash_id_otp and sees only its ports.
*/
`timescale 1ns/1ps
module flash_id_otp_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins and configuration
  input wire flash_id_otp_pkg::pins_t pin_in,
  input wire flash_id_otp_pkg::drive_t pin_drive,
  input wire logic quad_enable_bit,
  input wire logic [23:0] access_addr,
  // mode and permission state
  input wire logic four_line_command_mode,
  input wire logic otp_mode,
  input wire logic customer_lock_flag,
  input wire logic array_write_block,
  input wire logic status_write_block,
  input wire logic otp_program_allowed,
  input wire logic serial_number_hit,
  input wire logic otp_addr_valid
);
  // ==========================================================
  // properties
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // state may only move once the host has let go of the device
  sequence deselected;
    pin_in.cs_n && $past(pin_in.cs_n, 3);
  endsequence

  a_array_blocked: assert property (
    array_write_block == otp_mode || array_write_block == $past(otp_mode))
    else $error("array write block differs from otp mode");
  a_status_blocked: assert property (
    status_write_block == otp_mode || status_write_block == $past(otp_mode))
    else $error("status write block differs from otp mode");
  a_lock_sticky: assert property (
    customer_lock_flag |=> customer_lock_flag)
    else $error("customer lock cleared");
  a_lock_sets_idle: assert property (
    $rose(customer_lock_flag) |-> deselected and !otp_mode)
    else $error("customer lock set at wrong moment");
  a_locked_no_prog: assert property (
    customer_lock_flag && $past(customer_lock_flag) |-> !otp_program_allowed)
    else $error("program allowed while locked");
  a_qmode_needs_enable: assert property (
    $rose(four_line_command_mode) |-> $past(quad_enable_bit, 4))
    else $error("four-line mode entered without quad enable");
  a_mode_moves_idle: assert property (
    $changed(otp_mode) || $changed(four_line_command_mode) |-> deselected)
    else $error("mode changed while selected");
  a_sn_range: assert property (
    serial_number_hit |-> $past(access_addr) <= flash_id_otp_pkg::SN_LAST
      && (otp_mode || $past(otp_mode)))
    else $error("serial number hit outside its range");
  a_otp_range: assert property (
    otp_addr_valid |-> $past(access_addr) <= flash_id_otp_pkg::OTP_LAST)
    else $error("otp address valid outside range");
  a_oe_released: assert property (
    pin_in.cs_n [*5] |-> pin_drive.oe == 4'h0)
    else $error("data lines driven while deselected");

  // main scenarios reached
  c_qmode: cover property ($rose(four_line_command_mode));
  c_otp: cover property ($rose(otp_mode));
  c_lock: cover property ($rose(customer_lock_flag));
endmodule : flash_id_otp_checker

bind flash_id_otp flash_id_otp_checker i_chk (.clk, .reset_n, .pin_in,
  .pin_drive, .quad_enable_bit, .access_addr, .four_line_command_mode,
  .otp_mode, .customer_lock_flag, .array_write_block, .status_write_block,
  .otp_program_allowed, .serial_number_hit, .otp_addr_valid);

/* File: sim/host_ctl.sv */
/*
  Host controller model driving chip select, serial clock and data.
  Assumes clk of 5 ns; one link clock is 16 clk cycles (80 ns).
*/
`timescale 1ns/1ps
module host_ctl (
  // system clock
  input wire logic clk,
  // device pins
  output flash_id_otp_pkg::pins_t pins,
  input wire flash_id_otp_pkg::drive_t drive
);
  // ==========================================================
  // link cycles
  // deselected, clock parked low between frames
  initial pins = 6'h20;

  // one link clock; sampling late leaves the 3 clk answer time
  task automatic tick(input logic [3:0] v, output logic [3:0] s);
    @(negedge clk);
    pins.sclk = 1'b0;
    pins.io = v;
    repeat (8) @(negedge clk);
    // a line the device leaves released shows what the host drives
    s = (drive.out & drive.oe) | (v & ~drive.oe);
    pins.sclk = 1'b1;
    repeat (7) @(negedge clk);
  endtask : tick

  // select; the first rise comes 9 clk later
  task automatic open_cs();
    @(negedge clk);
    pins.cs_n = 1'b0;
  endtask : open_cs

  // bits msb first, upper lane first
  task automatic put(input logic [63:0] v, input int bits, input int lanes);
    logic [3:0] s;
    v = v << (64 - bits);
    for (int i = 0; i < bits / lanes; i++) begin
      tick(4'(v[63:60] >> (4 - lanes)), s);
      v = v << lanes;
    end
  endtask : put

  // lines left to the device toggle, so stale values never pass
  task automatic get(input int bits, input int lanes, output logic [63:0] rx);
    logic [3:0] s;
    logic [3:0] v;
    rx = '0;
    v = ~pins.io;
    for (int i = 0; i < bits / lanes; i++) begin
      tick(v, s);
      v = ~v;
      rx = (rx << lanes) | 64'(lanes == 1 ? {3'h0, s[1]} :
        s & 4'((1 << lanes) - 1));
    end
  endtask : get

  // park the clock low after the last rise, deselect 2 clk later, then keep the gap
  task automatic close_cs();
    @(negedge clk);
    pins.sclk = 1'b0;
    repeat (2) @(negedge clk);
    pins.cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : close_cs
endmodule : host_ctl

/* File: sim/tb.sv */
/*
  Self-checking bench for the ID, four-line mode and OTP slice.
  Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] MKR = 8'hc3; // arbitrary value
  localparam logic [7:0] DEV = 8'h6e; // arbitrary value
  localparam logic [7:0] TYP = 8'h41; // arbitrary value
  localparam logic [7:0] CAP = 8'h9d; // arbitrary value
  localparam logic [23:0] ADR [5] = '{24'h0, 24'hf, 24'h10, 24'h1ff, 24'h200};
  // design inputs, all set at time zero
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic quad_enable_bit = 1'b0;
  logic factory_lock_in = 1'b0;
  logic customer_lock_in = 1'b0;
  logic [23:0] access_addr = 24'h0;
  flash_id_otp_pkg::pins_t pins;
  flash_id_otp_pkg::drive_t drive;
  logic four_line_command_mode, otp_mode, customer_lock_flag;
  logic array_write_block, status_write_block, otp_program_allowed;
  logic serial_number_hit, otp_addr_valid;
  logic [63:0] rx;
  int errors = 0;
  int samples_checked = 0;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  host_ctl i_host_ctl (.clk, .pins, .drive);
  flash_id_otp #(.MAKER_ID(MKR), .DEVICE_ID(DEV), .MEM_TYPE(TYP),
    .CAPACITY(CAP)) i_flash_id_otp (.clk, .reset_n, .pin_in(pins),
    .pin_drive(drive), .quad_enable_bit, .factory_lock_in,
    .customer_lock_in, .access_addr, .four_line_command_mode, .otp_mode,
    .customer_lock_flag, .array_write_block, .status_write_block,
    .otp_program_allowed, .serial_number_hit, .otp_addr_valid);

  // ==========================================================
  // compare and closing
  task automatic chk_flag(input logic got, input logic exp, input string s);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s", $time, s);
    end
  endtask : chk_flag
  task automatic chk_data(input logic [63:0] got, input logic [63:0] exp,
    input string s);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h", $time, s, got);
    end
  endtask : chk_data
  task automatic end_of_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // helpers
  task automatic do_reset(input logic f, input logic c);
    @(negedge clk);
    reset_n = 1'b0;
    factory_lock_in = f;
    customer_lock_in = c;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : do_reset
  task automatic send(input logic [7:0] op, input int lanes);
    i_host_ctl.open_cs();
    i_host_ctl.put(64'(op), 8, lanes);
    i_host_ctl.close_cs();
  endtask : send
  // extra adds one clock past the data byte, which must be refused
  task automatic wsec(input logic [7:0] d, input logic extra);
    i_host_ctl.open_cs();
    i_host_ctl.put(64'({flash_id_otp_pkg::OP_SEC_WRITE, d}), 16, 1);
    if (extra) i_host_ctl.put(64'h0, 1, 1);
    i_host_ctl.close_cs();
  endtask : wsec

  // ==========================================================
  // scenarios
  task automatic t_idle();
    chk_flag(four_line_command_mode, 1'b0, "serial mode at start");
    chk_flag(otp_mode, 1'b0, "otp mode at start");
    chk_data(64'(drive.oe), 64'h0, "lines released at start");
  endtask : t_idle
  task automatic t_std_id(input int lanes);
    i_host_ctl.open_cs();
    i_host_ctl.put(64'(flash_id_otp_pkg::OP_ID_STD), 8, lanes);
    i_host_ctl.get(48, lanes, rx);
    i_host_ctl.close_cs();
    chk_data(rx, {16'h0, MKR, TYP, CAP, MKR, TYP, CAP}, "std id");
  endtask : t_std_id
  task automatic t_mfr_id(input logic [7:0] op, input int lanes, input int gap);
    for (int a = 0; a < 2; a++) begin
      i_host_ctl.open_cs();
      i_host_ctl.put(64'(op), 8, 1);
      i_host_ctl.put(64'(a) << 8, 32, lanes);
      if (gap > 0) i_host_ctl.get(gap * lanes, lanes, rx);
      i_host_ctl.get(32, lanes, rx);
      i_host_ctl.close_cs();
      chk_data(rx, (a == 1) ? {32'h0, DEV, MKR, DEV, MKR} :
        {32'h0, MKR, DEV, MKR, DEV}, "id pair");
    end
  endtask : t_mfr_id
  task automatic t_sec_read(input logic [7:0] e);
    i_host_ctl.open_cs();
    i_host_ctl.put(64'(flash_id_otp_pkg::OP_SEC_READ), 8, 1);
    i_host_ctl.get(16, 1, rx);
    i_host_ctl.close_cs();
    chk_data(rx, {48'h0, e, e}, "security byte");
  endtask : t_sec_read
  task automatic t_otp();
    send(flash_id_otp_pkg::OP_OTP_ENTER, 1);
    chk_flag(otp_mode, 1'b1, "otp entry");
    chk_flag(array_write_block, 1'b1, "array writes blocked");
    chk_flag(status_write_block, 1'b1, "status writes blocked");
    chk_flag(otp_program_allowed, 1'b1, "unlocked otp programmable");
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      access_addr = ADR[i];
      repeat (3) @(negedge clk);
      chk_flag(serial_number_hit, 1'(i < 2), "serial number field");
      chk_flag(otp_addr_valid, 1'(i < 4), "otp range");
    end
    wsec(8'h02, 1'b0);
    chk_flag(customer_lock_flag, 1'b0, "lock write in otp mode");
    send(flash_id_otp_pkg::OP_OTP_EXIT, 1);
    chk_flag(otp_mode, 1'b0, "otp exit");
    chk_flag(array_write_block, 1'b0, "array writes back");
  endtask : t_otp
  task automatic t_lock();
    i_host_ctl.open_cs();
    i_host_ctl.put(64'({flash_id_otp_pkg::OP_SEC_WRITE, 8'h02} >> 1), 15, 1);
    i_host_ctl.close_cs();
    chk_flag(customer_lock_flag, 1'b0, "lock with early deselect");
    wsec(8'h02, 1'b1);
    chk_flag(customer_lock_flag, 1'b0, "lock with extra clock");
    wsec(8'h02, 1'b0);
    chk_flag(customer_lock_flag, 1'b1, "lock without enable");
    t_sec_read(8'h02);
    send(flash_id_otp_pkg::OP_OTP_ENTER, 1);
    chk_flag(otp_program_allowed, 1'b0, "locked otp program");
    send(flash_id_otp_pkg::OP_OTP_EXIT, 1);
    wsec(8'h00, 1'b0);
    chk_flag(customer_lock_flag, 1'b1, "lock stays set");
  endtask : t_lock
  task automatic t_qmode();
    send(flash_id_otp_pkg::OP_QMODE_ON, 1);
    chk_flag(four_line_command_mode, 1'b0, "entry without enable");
    quad_enable_bit = 1'b1;
    send(flash_id_otp_pkg::OP_QMODE_ON, 1);
    chk_flag(four_line_command_mode, 1'b1, "entry");
    t_std_id(4);
    send(flash_id_otp_pkg::OP_QMODE_ON, 4);
    chk_flag(four_line_command_mode, 1'b1, "entry refused in mode");
    send(flash_id_otp_pkg::OP_QMODE_OFF, 4);
    chk_flag(four_line_command_mode, 1'b0, "single exit");
    send(flash_id_otp_pkg::OP_QMODE_ON, 1);
    i_host_ctl.open_cs();
    i_host_ctl.put(64'hff0, 12, 4);
    i_host_ctl.close_cs();
    chk_flag(four_line_command_mode, 1'b1, "spoiled all ones exit");
    i_host_ctl.open_cs();
    i_host_ctl.put(64'hffff, 16, 4);
    i_host_ctl.close_cs();
    chk_flag(four_line_command_mode, 1'b0, "all ones exit");
  endtask : t_qmode

  // ==========================================================
  // main sequence
  initial begin
    do_reset(1'b0, 1'b0);
    t_idle();
    t_std_id(1);
    t_mfr_id(flash_id_otp_pkg::OP_ID_DUAL, 2, 0);
    t_mfr_id(flash_id_otp_pkg::OP_ID_QUAD, 4, 4);
    t_sec_read(8'h00);
    t_otp();
    t_lock();
    t_qmode();
    do_reset(1'b1, 1'b1);
    t_sec_read(8'h03);
    end_of_test();
  end

  // watchdog: about three times the roughly 7150 cycles of scenarios
  initial begin
    repeat (24000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule : tb
